// file: design/line_sync.sv
module line_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);

  logic meta;

  // Two stages before any logic sees the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= RESET_VALUE;
      q    <= RESET_VALUE;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// file: design/rate_tick_gen.sv
module rate_tick_gen #(
  parameter int RELOAD_BITS = serial_port_pkg::RELOAD_WIDTH
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [1:0]             mode,
  input  wire logic                   smod,
  input  wire logic                   rate_source_select,
  input  wire logic [RELOAD_BITS-1:0] rate_reload_value,
  input  wire logic                   timer1_overflow,
  output logic                        tick
);

  logic                   pre;
  logic                   half;
  logic                   raw;
  logic [RELOAD_BITS-1:0] count;

  // Prescaler: one pulse every two clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pre <= 1'b0;
    else       pre <= ~pre;
  end

  // Reload counter, period of 1024 minus reload prescaled steps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (pre) begin
      if (&count) count <= rate_reload_value;
      else        count <= count + 1'b1;
    end
  end

  // Source selection for the oversampling tick
  always_comb begin
    if (mode == serial_port_pkg::MODE_UART9_FIXED)
      raw = pre;
    else if (rate_source_select)
      raw = pre && (&count);
    else
      raw = timer1_overflow;
  end

  // Halving stage bypassed when doubling is set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half <= 1'b0;
      tick <= 1'b0;
    end else begin
      if (raw) half <= ~half;
      tick <= raw && (smod || half);
    end
  end

endmodule

// file: design/serial_port_pkg.sv
package serial_port_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL     = 8'h98;
  localparam logic [7:0] ADDR_BUFFER      = 8'h99;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hAA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hBA;
  localparam logic [7:0] ADDR_RATE_SELECT = 8'hD8;
  localparam logic [7:0] ADDR_POWER       = 8'h87;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] BUFFER_RESET      = 8'h00;
  localparam logic [7:0] RELOAD_LOW_RESET  = 8'hD9;
  localparam logic [7:0] RELOAD_HIGH_RESET = 8'h03;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_MODE_HIGH   = 7;
  localparam int CTL_MODE_LOW    = 6;
  localparam int CTL_MULTIPROC   = 5;
  localparam int CTL_RX_ENABLE   = 4;
  localparam int CTL_TX_NINTH    = 3;
  localparam int RATE_SOURCE_BIT = 7;
  localparam int SMOD_BIT        = 7;
  localparam int RELOAD_WIDTH    = 10;
  localparam int RELOAD_HIGH_MSB = 1;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [3:0] SHIFT_CLOCK_DIV  = 4'hC;
  localparam logic [3:0] SHIFT_CLOCK_HALF = 4'h6;
  localparam logic [3:0] OVERSAMPLE_LAST  = 4'hF;
  localparam logic [3:0] OVERSAMPLE_MID   = 4'h7;
  localparam logic [3:0] BITS_EIGHT       = 4'h8;
  localparam logic [3:0] BITS_NINE        = 4'h9;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_SHIFT       = 2'h0,
    MODE_UART8       = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR   = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_DATA  = 2'h3,
    ST_STOP  = 2'h2
  } frame_state_t;

endpackage

// file: design/serial_port_uart.sv
// Notes on behaviour
// - Mode bits select clk/12 shifter, 8-bit, fixed or variable 9-bit.
// - Fixed 9-bit mode runs at clk/64, or clk/32 when doubling is set.
// - Reception starts only while the receive enable bit is one.
// - Nine-bit modes send control bit 3 as the ninth data bit.
// - Nine-bit modes store the ninth received bit in control bit 2.
// - Transmit done set after bit 8 in mode 0, at stop start otherwise.
// - Receive done set after bit 8 in mode 0, mid stop otherwise.
// - Rate source zero scales Timer 1 overflow by doubling flag over 32.
// - Rate source one: doubling times clk over 64 times (1024 - reload).
// - Reload is eight low-register bits plus two low high-register bits.
// - Buffer write loads and starts transmit; read returns received byte.
// - Doubling flag is bit 7 of the power control register.
// - Shift clock, fixed and reload rates come from the system clock; rate source zero uses Timer 1 overflow.
// - Rate source select is bit 7 at 0xD8, reset zero.
//
// The address-and-strobe port was left to the implementer.
module serial_port_uart (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd,
  input  wire logic       timer1_overflow
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:3] ctl_sw;
  logic       rx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic [7:0] rate_reload_low;
  logic [7:0] rate_reload_high;
  logic       rate_source_select;
  logic       smod;
  logic [7:0] rx_buf;

  logic [1:0] mode;
  logic       nine;
  logic       receive_enable;
  logic       multiproc_enable;
  logic       tx_ninth_bit;
  logic [9:0] rate_reload_value;
  logic       tick;
  logic       rxd_s;
  logic       rxd_prev;
  logic wr_ctl;
  logic wr_buf;
  logic wr_low;
  logic wr_high;
  logic wr_sel;
  logic wr_pwr;
  serial_port_pkg::frame_state_t tx_state;
  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [3:0] tx_tick;
  logic [3:0] m0_cnt;
  logic       m0_rx;
  logic       m0_rx_done;
  logic       tx_step;
  logic       tx_last;
  logic       tx_done_set;
  serial_port_pkg::frame_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_bits;
  logic [3:0] rx_tick;
  logic       rx_end;
  logic       rx_accept;
  logic       rx_load;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Write strobes per register
  assign wr_ctl  = wr && hit(addr, serial_port_pkg::ADDR_CONTROL);
  assign wr_buf  = wr && hit(addr, serial_port_pkg::ADDR_BUFFER);
  assign wr_low  = wr && hit(addr, serial_port_pkg::ADDR_RELOAD_LOW);
  assign wr_high = wr && hit(addr, serial_port_pkg::ADDR_RELOAD_HIGH);
  assign wr_sel  = wr && hit(addr, serial_port_pkg::ADDR_RATE_SELECT);
  assign wr_pwr  = wr && hit(addr, serial_port_pkg::ADDR_POWER);

  // Control fields
  assign mode = ctl_sw[serial_port_pkg::CTL_MODE_HIGH:
                       serial_port_pkg::CTL_MODE_LOW];
  assign nine = mode[1];
  assign receive_enable   = ctl_sw[serial_port_pkg::CTL_RX_ENABLE];
  assign multiproc_enable = ctl_sw[serial_port_pkg::CTL_MULTIPROC];
  assign tx_ninth_bit     = ctl_sw[serial_port_pkg::CTL_TX_NINTH];
  assign rate_reload_value = {rate_reload_high[serial_port_pkg::
                              RELOAD_HIGH_MSB:0], rate_reload_low};

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Software-owned control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)       ctl_sw <= serial_port_pkg::CONTROL_RESET[7:3];
    else if (wr_ctl) ctl_sw <= wdata[7:3];
  end

  // Reload, rate source and doubling registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_reload_low    <= serial_port_pkg::RELOAD_LOW_RESET;
      rate_reload_high   <= serial_port_pkg::RELOAD_HIGH_RESET;
      rate_source_select <= 1'b0;
      smod               <= 1'b0;
    end else begin
      if (wr_low)  rate_reload_low  <= wdata;
      if (wr_high) rate_reload_high <= wdata;
      if (wr_sel)
        rate_source_select <= wdata[serial_port_pkg::RATE_SOURCE_BIT];
      if (wr_pwr)  smod <= wdata[serial_port_pkg::SMOD_BIT];
    end
  end

  // Ninth received bit, hardware load beats software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)                rx_ninth_bit <= 1'b0;
    else if (rx_load && nine) rx_ninth_bit <= rx_shift[8];
    else if (wr_ctl)          rx_ninth_bit <= wdata[2];
  end

  // Completion flags, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      if (tx_done_set)  tx_done_flag <= 1'b1;
      else if (wr_ctl)  tx_done_flag <= wdata[1];
      if (rx_load || m0_rx_done) rx_done_flag <= 1'b1;
      else if (wr_ctl)           rx_done_flag <= wdata[0];
    end
  end

  // Receive buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)           rx_buf <= serial_port_pkg::BUFFER_RESET;
    else if (m0_rx_done) rx_buf <= tx_shift[9:2];
    else if (rx_load)    rx_buf <= nine ? rx_shift[7:0] : rx_shift[8:1];
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= serial_port_pkg::READ_ZERO;
    end else if (rd) begin
      case (addr)
        serial_port_pkg::ADDR_CONTROL:
          rdata <= {ctl_sw, rx_ninth_bit, tx_done_flag, rx_done_flag};
        serial_port_pkg::ADDR_BUFFER:      rdata <= rx_buf;
        serial_port_pkg::ADDR_RELOAD_LOW:  rdata <= rate_reload_low;
        serial_port_pkg::ADDR_RELOAD_HIGH: rdata <= rate_reload_high;
        serial_port_pkg::ADDR_RATE_SELECT: rdata <= {rate_source_select,
                                                     7'h00};
        serial_port_pkg::ADDR_POWER:       rdata <= {smod, 7'h00};
        default:                           rdata <= serial_port_pkg::READ_ZERO;
      endcase
    end else begin
      rdata <= serial_port_pkg::READ_ZERO;
    end
  end

  // ****************************************************************
  // Rate generation and line input
  // ****************************************************************
  // Oversampling tick from clk, or from timer1_overflow when rate source is zero outside mode 2
  rate_tick_gen #(
    .RELOAD_BITS (serial_port_pkg::RELOAD_WIDTH)
  ) u_rate (
    .clk                (clk),
    .rstn               (rstn),
    .mode               (mode),
    .smod               (smod),
    .rate_source_select (rate_source_select),
    .rate_reload_value  (rate_reload_value),
    .timer1_overflow    (timer1_overflow),
    .tick               (tick)
  );

  line_sync #(
    .RESET_VALUE (1'b1)
  ) u_rx_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (rxd_in),
    .q    (rxd_s)
  );

  // Previous line level for start edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rxd_prev <= 1'b1;
    else       rxd_prev <= rxd_s;
  end

  // ****************************************************************
  // Transmitter and mode 0 shifter
  // ****************************************************************
  // Bit step: clk/12 in mode 0, sixteen ticks in UART modes
  assign tx_step = (mode == serial_port_pkg::MODE_SHIFT) ?
                   (m0_cnt == serial_port_pkg::SHIFT_CLOCK_DIV - 4'h1) :
                   (tick && tx_tick == serial_port_pkg::OVERSAMPLE_LAST);
  assign tx_last = (tx_state == serial_port_pkg::ST_DATA) && tx_step &&
                   (tx_bits == 4'h1);
  assign tx_done_set = tx_last && !m0_rx;

  // Shift clock divider for mode 0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      m0_cnt <= 4'h0;
    else if (tx_state == serial_port_pkg::ST_IDLE || tx_step)
      m0_cnt <= 4'h0;
    else
      m0_cnt <= m0_cnt + 4'h1;
  end

  // Oversample counter for transmit bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      tx_tick <= 4'h0;
    else if (tx_state == serial_port_pkg::ST_IDLE)
      tx_tick <= 4'h0;
    else if (tick)
      tx_tick <= tx_tick + 4'h1;
  end

  // Transmit state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= serial_port_pkg::ST_IDLE;
      tx_shift <= 10'h3FF;
      tx_bits  <= 4'h0;
      m0_rx    <= 1'b0;
    end else begin
      case (tx_state)
        serial_port_pkg::ST_IDLE: begin
          if (wr_buf) begin
            tx_shift <= {1'b1, nine ? tx_ninth_bit : 1'b1, wdata};
            tx_bits  <= nine ? serial_port_pkg::BITS_NINE :
                               serial_port_pkg::BITS_EIGHT;
            m0_rx    <= 1'b0;
            tx_state <= (mode == serial_port_pkg::MODE_SHIFT) ?
                        serial_port_pkg::ST_DATA : serial_port_pkg::ST_START;
          end else if (mode == serial_port_pkg::MODE_SHIFT &&
                       receive_enable && !rx_done_flag) begin
            tx_shift <= 10'h3FF;
            tx_bits  <= serial_port_pkg::BITS_EIGHT;
            m0_rx    <= 1'b1;
            tx_state <= serial_port_pkg::ST_DATA;
          end
        end
        serial_port_pkg::ST_START: begin
          if (tx_step) tx_state <= serial_port_pkg::ST_DATA;
        end
        serial_port_pkg::ST_DATA: begin
          if (tx_step) begin
            tx_shift <= {m0_rx ? rxd_s : 1'b1, tx_shift[9:1]};
            tx_bits  <= tx_bits - 4'h1;
            if (tx_bits == 4'h1)
              tx_state <= (mode == serial_port_pkg::MODE_SHIFT) ?
                          serial_port_pkg::ST_IDLE :
                          serial_port_pkg::ST_STOP;
          end
        end
        serial_port_pkg::ST_STOP: begin
          if (tx_step) tx_state <= serial_port_pkg::ST_IDLE;
        end
        default: tx_state <= serial_port_pkg::ST_IDLE;
      endcase
    end
  end

  // Mode 0 receive completion, one cycle after the last shift
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) m0_rx_done <= 1'b0;
    else       m0_rx_done <= tx_last && m0_rx;
  end

  // Pin drivers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else if (mode == serial_port_pkg::MODE_SHIFT) begin
      txd     <= !(tx_state != serial_port_pkg::ST_IDLE &&
                   m0_cnt < serial_port_pkg::SHIFT_CLOCK_HALF);
      rxd_out <= tx_shift[0];
      rxd_oe  <= (tx_state != serial_port_pkg::ST_IDLE) && !m0_rx;
    end else begin
      case (tx_state)
        serial_port_pkg::ST_START: txd <= 1'b0;
        serial_port_pkg::ST_DATA:  txd <= tx_shift[0];
        default:                   txd <= 1'b1;
      endcase
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end
  end

  // ****************************************************************
  // UART receiver
  // ****************************************************************
  // Frame end and acceptance in mid stop bit
  assign rx_end = (rx_state == serial_port_pkg::ST_STOP) && tick &&
                  (rx_tick == serial_port_pkg::OVERSAMPLE_LAST);
  assign rx_accept = !rx_done_flag &&
                     (!multiproc_enable ||
                      (nine ? rx_shift[8] : rxd_s));
  assign rx_load = rx_end && rx_accept;

  // Receive state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= serial_port_pkg::ST_IDLE;
      rx_shift <= 9'h000;
      rx_bits  <= 4'h0;
      rx_tick  <= 4'h0;
    end else begin
      if (tick) rx_tick <= rx_tick + 4'h1;
      case (rx_state)
        serial_port_pkg::ST_IDLE: begin
          rx_tick <= 4'h0;
          if (mode != serial_port_pkg::MODE_SHIFT && receive_enable &&
              rxd_prev && !rxd_s)
            rx_state <= serial_port_pkg::ST_START;
        end
        serial_port_pkg::ST_START: begin
          if (tick && rx_tick == serial_port_pkg::OVERSAMPLE_MID) begin
            rx_tick  <= 4'h0;
            rx_bits  <= nine ? serial_port_pkg::BITS_NINE :
                               serial_port_pkg::BITS_EIGHT;
            rx_state <= rxd_s ? serial_port_pkg::ST_IDLE :
                                serial_port_pkg::ST_DATA;
          end
        end
        serial_port_pkg::ST_DATA: begin
          if (tick && rx_tick == serial_port_pkg::OVERSAMPLE_LAST) begin
            rx_shift <= {rxd_s, rx_shift[8:1]};
            rx_bits  <= rx_bits - 4'h1;
            if (rx_bits == 4'h1) rx_state <= serial_port_pkg::ST_STOP;
          end
        end
        serial_port_pkg::ST_STOP: begin
          if (rx_end) rx_state <= serial_port_pkg::ST_IDLE;
        end
        default: rx_state <= serial_port_pkg::ST_IDLE;
      endcase
    end
  end

endmodule

// file: tb/serial_peer.sv
module serial_peer (
  input wire logic clk,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line idles high between frames
  initial rxd = 1'b1;

  // Start low, data LSB first, stop high, each bc clocks
  task automatic send(input logic [8:0] d, input int nb, input int bc);
    for (int i = 0; i < nb + 2; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1];
      repeat (bc) @(posedge clk);
    end
  endtask

  // Shift mode: present one bit just after a clock edge
  task automatic put(input logic d);
    @(posedge clk);
    rxd <= d;
  endtask
endmodule

// file: tb/serial_port_properties.sv
module serial_port_properties (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rxd_out,
  input wire logic       rxd_oe,
  input wire logic       txd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Shadow of software writes
  // ****************************************************************
  logic [1:0] mode;
  logic       smod;
  logic [7:0] rel_low;

  // Track mode, doubling flag and reload low as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode    <= 2'h0;
      smod    <= 1'b0;
      rel_low <= 8'hD9;
    end else begin
      if (wr && addr == 8'h98)
        mode <= wdata[7:6];
      if (wr && addr == 8'h87)
        smod <= wdata[7];
      if (wr && addr == 8'hAA)
        rel_low <= wdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read data stands only in the cycle after a read
  a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd && !(addr inside {8'h98,
    8'h99, 8'hAA, 8'hBA, 8'hD8, 8'h87}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reload_read: assert property (rd && addr == 8'hAA
    |=> rdata == $past(rel_low))
    else $error("reload low readback wrong");
  a_oe_shift_only: assert property (rxd_oe |-> mode == 2'h0)
    else $error("pin driven outside shift mode");
  a_shift_clk_low: assert property ($fell(txd) && mode == 2'h0
    |-> (!txd)[*6] ##1 txd)
    else $error("shift clock low phase wrong");
  a_shift_data_hold: assert property (rxd_oe && $rose(txd)
    |-> $stable(rxd_out))
    else $error("shift data moved at clock rise");
  a_tx_start_low: assert property (wr && addr == 8'h99
    && mode != 2'h0 |-> ##[2:3] !txd)
    else $error("no start bit after buffer write");
  a_start_bit_len: assert property (wr && addr == 8'h99
    && mode == 2'h2 && !smod |-> ##2 !txd ##60 !txd)
    else $error("fixed rate start bit too short");

  cover property ($rose(rxd_oe));
  cover property ($fell(txd) && mode == 2'h2);
  cover property (rd && addr == 8'hAA);
endmodule

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rstn, wr, rd, rxd, rxd_out, rxd_oe, txd;
  logic       ovf = 1'b0;
  logic       ovf_on = 1'b0;
  logic [1:0] oc = 2'h0;
  logic [7:0] addr, wdata, rdata, v, b;
  logic [9:0] got;
  int         num_errors = 0;
  int         comparisons = 0;
  logic [7:0] ra [7] = '{8'h98, 8'h99, 8'hAA, 8'hBA, 8'hD8, 8'h87, 8'h55};
  logic [9:0] rv [7] = '{10'h0, 10'h0, 10'hD9, 10'h3, 10'h0, 10'h0, 10'h0};
  logic [7:0] rc [4] = '{8'hC0, 8'hF0, 8'hD0, 8'hF0};
  logic [7:0] re [4] = '{8'hC0, 8'hF0, 8'hD5, 8'hF5};
  logic       rn [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  serial_port_uart dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd_in(rxd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd(txd), .timer1_overflow(ovf));
  serial_peer peer_u (.clk(clk), .rxd(rxd));

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Timer overflow pulse every fourth clock when enabled
  always @(posedge clk) begin
    oc  <= oc + 2'h1;
    ovf <= ovf_on && oc == 2'h3;
  end

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [9:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = {2'h0, rdata};
  endtask

  // Bounded wait for a line level
  task automatic wait_lvl(ref logic s, input logic l);
    int n;
    n = 0;
    while (s !== l) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        num_errors++;
        $display("CHECK FAILED at %0t: line wait timed out", $time);
        stop_test();
      end
    end
  endtask

  // Capture a frame mid-bit; stop bit lands above the data
  task automatic grab(input int nb, input int bc, output logic [9:0] f);
    f = 10'h0;
    wait_lvl(txd, 1'b0);
    repeat (bc / 2) @(negedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bc) @(negedge clk);
      f[i] = txd;
    end
    repeat (bc) @(negedge clk);
  endtask

  initial begin
    {rstn, wr, rd, addr, wdata} = 19'h0;
    void'($urandom(5));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and an unmapped address
    foreach (ra[i]) begin
      rd_reg(ra[i], got);
      check(got, rv[i]);
    end
    v = 8'($urandom);
    wr_reg(8'hAA, v);
    wr_reg(8'hD8, 8'hFF);
    rd_reg(8'hAA, got);
    check(got, {2'h0, v});
    rd_reg(8'hD8, got);
    check(got, 10'h080);
    // Fixed rate nine bit transmit at both doubling settings
    for (int s = 0; s < 2; s++) begin
      v = 8'($urandom);
      b = 8'($urandom) & 8'h08;
      wr_reg(8'h87, s[0] ? 8'h80 : 8'h00);
      wr_reg(8'h98, 8'h80 | b);
      wr_reg(8'h99, v);
      grab(9, s[0] ? 32 : 64, got);
      check(got, {1'b1, b[3], v});
      rd_reg(8'h98, got);
      check(got, {2'h0, 8'h82 | b});
    end
    // Eight bit transmit from timer overflow
    ovf_on <= 1'b1;
    wr_reg(8'hD8, 8'h00);
    wr_reg(8'h98, 8'h40);
    v = 8'($urandom);
    wr_reg(8'h99, v);
    grab(8, 64, got);
    check(got, {2'h1, v});
    // Variable rate receive from the reload generator
    wr_reg(8'hD8, 8'h80);
    wr_reg(8'hAA, 8'hFE);
    wr_reg(8'hBA, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr_reg(8'h98, rc[k]);
      peer_u.send({rn[k], v}, 9, 64);
      repeat (40) @(posedge clk);
      rd_reg(8'h98, got);
      check(got, {2'h0, re[k]});
      if (re[k][0]) begin
        rd_reg(8'h99, got);
        check(got, {2'h0, v});
      end
    end
    // Shift register transmit
    wr_reg(8'h98, 8'h00);
    v = 8'($urandom);
    wr_reg(8'h99, v);
    got = 10'h0;
    for (int i = 0; i < 8; i++) begin
      wait_lvl(txd, 1'b0);
      wait_lvl(txd, 1'b1);
      got[i] = rxd_out;
      check({9'h0, rxd_oe}, 10'h001);
    end
    check(got, {2'h0, v});
    repeat (16) @(posedge clk);
    rd_reg(8'h98, got);
    check(got, 10'h002);
    // Shift register receive, peer follows the shift clock
    wr_reg(8'h98, 8'h10);
    v = 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      wait_lvl(txd, 1'b0);
      peer_u.put(v[i]);
      check({9'h0, rxd_oe}, 10'h000);
      wait_lvl(txd, 1'b1);
    end
    peer_u.put(1'b1);
    repeat (16) @(posedge clk);
    rd_reg(8'h98, got);
    check(got, 10'h011);
    rd_reg(8'h99, got);
    check(got, {2'h0, v});
    stop_test();
  end
endmodule

bind serial_port_uart serial_port_properties props_u (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
